// File: design/lip_top.sv
// design: apb-mapped led intensity registers with master and per-pin pwm generation
//
// Register access over APB was left to the implementer.
`default_nettype none
module lip_top (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire lip_pkg::lip_apb_req_t apb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic first_port_pin_o,
  output logic second_port_pin_o,
  output logic ninth_port_pin_o,
  output logic osc_running_o
);
  import lip_pkg::*;

  // address decode shared by read mux, write enables and error reply
  function automatic logic lip_hit(input logic [LIP_ADDR_W-1:0] addr, input logic [7:0] idx);
    lip_hit = (addr == LIP_ADDR_W'({idx, 2'b00}));
  endfunction

  // one pin's level for a given code, slot and master gate
  function automatic logic lip_pin_level(
    input logic [3:0] code,
    input logic [3:0] slot,
    input logic [3:0] sub,
    input logic [3:0] master
  );
    logic on;
    on = 1'b0;
    if (master == LIP_CODE_OFF) begin
      on = 1'b0;
    end else if (code == LIP_CODE_FULL) begin
      on = 1'b1;
    end else begin
      on = (slot <= code) && (sub < master);
    end
    lip_pin_level = on;
  endfunction

  // ---------------- registers ----------------
  logic [7:0] master_ninth_ff;
  logic [7:0] first_second_ff;
  logic [7:0] nxt_master_ninth;
  logic [7:0] nxt_first_second;

  logic [15:0] div_ff;
  logic [15:0] nxt_div;
  logic [3:0] sub_ff;
  logic [3:0] nxt_sub;
  logic [3:0] slot_ff;
  logic [3:0] nxt_slot;
  logic run_ff;

  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;

  lip_pins_t pins_ff;
  lip_pins_t nxt_pins;

  // ---------------- apb decode ----------------
  wire logic setup_phase = apb_i.psel & ~apb_i.penable;
  wire logic access_done = apb_i.psel & apb_i.penable & pready_ff;
  wire logic hit_master = lip_hit(apb_i.paddr, LIP_IDX_MASTER_NINTH);
  wire logic hit_outs = lip_hit(apb_i.paddr, LIP_IDX_FIRST_SECOND);
  wire logic hit_status = lip_hit(apb_i.paddr, LIP_IDX_STATUS);
  wire logic mapped = hit_master | hit_outs | hit_status;
  // status is read only; a write to it is refused with an error reply
  wire logic bad_access = ~mapped | (hit_status & apb_i.pwrite);
  wire logic wr_ok = access_done & apb_i.pwrite & apb_i.pstrb[0] & ~bad_access;
  wire logic wr_master = wr_ok & hit_master;
  wire logic wr_outs = wr_ok & hit_outs;

  assign nxt_master_ninth = wr_master ? apb_i.pwdata[7:0] : master_ninth_ff;
  assign nxt_first_second = wr_outs ? apb_i.pwdata[7:0] : first_second_ff;

  // ---------------- field extraction ----------------
  wire logic [3:0] master_code = master_ninth_ff[LIP_HI_NIB_LSB +: LIP_NIB_W];
  wire logic [3:0] ninth_code = master_ninth_ff[LIP_LO_NIB_LSB +: LIP_NIB_W];
  wire logic [3:0] second_code = first_second_ff[LIP_HI_NIB_LSB +: LIP_NIB_W];
  wire logic [3:0] first_code = first_second_ff[LIP_LO_NIB_LSB +: LIP_NIB_W];

  // ---------------- read path ----------------
  wire logic [31:0] status_word = {20'h00000, sub_ff, slot_ff, 3'b000, run_ff};
  wire logic [31:0] read_word =
    hit_master ? {24'h000000, master_ninth_ff} :
    hit_outs ? {24'h000000, first_second_ff} :
    hit_status ? status_word : 32'h00000000;

  // data is latched in the setup cycle so the access phase completes in one cycle
  assign nxt_prdata = (setup_phase & ~apb_i.pwrite) ? read_word : prdata_ff;
  assign nxt_pready = setup_phase;
  assign nxt_pslverr = setup_phase & bad_access;

  // ---------------- internal oscillator ----------------
  // a zero master code gates the divider off and parks the counters at zero
  wire logic osc_en = (master_code != LIP_CODE_OFF);
  wire logic osc_tick = osc_en & (div_ff == LIP_OSC_DIV_CYC - 16'h0001);
  wire logic sub_wrap = osc_tick & (sub_ff == LIP_MASTER_LAST_SUB);

  assign nxt_div = !osc_en ? 16'h0000 :
                   osc_tick ? 16'h0000 : div_ff + 16'h0001;
  // fifteen sub ticks per slot carry the master duty of code fifteenths
  assign nxt_sub = !osc_en ? 4'h0 :
                   sub_wrap ? 4'h0 :
                   osc_tick ? sub_ff + 4'h1 : sub_ff;
  // sixteen slots form one output period; the last slot wraps naturally
  assign nxt_slot = !osc_en ? 4'h0 :
                    sub_wrap ? slot_ff + 4'h1 : slot_ff;

  // ---------------- pwm compare ----------------
  logic [3:0] pin_code [LIP_NUM_PINS];
  logic [LIP_NUM_PINS-1:0] pin_level;

  assign pin_code[0] = first_code;
  assign pin_code[1] = second_code;
  assign pin_code[2] = ninth_code;

  // pin is high for slots 0..code, i.e. (code+1)/16, then gated by the master sub ticks except at code f, which stays on while master is nonzero
  genvar gi;
  generate
    for (gi = 0; gi < LIP_NUM_PINS; gi++) begin : g_pin
      assign pin_level[gi] = lip_pin_level(pin_code[gi], slot_ff, sub_ff, master_code);
    end
  endgenerate

  assign nxt_pins.first_port_pin = pin_level[0];
  assign nxt_pins.second_port_pin = pin_level[1];
  assign nxt_pins.ninth_port_pin = pin_level[2];

  // ---------------- flip-flops ----------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      master_ninth_ff <= LIP_RST_MASTER_NINTH;
      first_second_ff <= LIP_RST_FIRST_SECOND;
    end else begin
      master_ninth_ff <= nxt_master_ninth;
      first_second_ff <= nxt_first_second;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      div_ff <= 16'h0000;
      sub_ff <= 4'h0;
      slot_ff <= 4'h0;
      run_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      sub_ff <= nxt_sub;
      slot_ff <= nxt_slot;
      run_ff <= osc_en;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pins_ff <= '0;
    end else begin
      pins_ff <= nxt_pins;
    end
  end

  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign first_port_pin_o = pins_ff.first_port_pin;
  assign second_port_pin_o = pins_ff.second_port_pin;
  assign ninth_port_pin_o = pins_ff.ninth_port_pin;
  assign osc_running_o = run_ff;
endmodule
`default_nettype wire

// File: design/lip_pkg.sv
// package: register map, field layout, reset values and timing for the led intensity block
`default_nettype none
package lip_pkg;
  // printed register offsets are word indices; the byte address is four times the index
  localparam logic [7:0] LIP_IDX_STATUS = 8'h01;
  localparam logic [7:0] LIP_IDX_MASTER_NINTH = 8'h0e;
  localparam logic [7:0] LIP_IDX_FIRST_SECOND = 8'h10;
  localparam int LIP_ADDR_W = 12;

  // field positions inside the two intensity registers
  localparam int LIP_HI_NIB_LSB = 4;
  localparam int LIP_LO_NIB_LSB = 0;
  localparam int LIP_NIB_W = 4;

  // status register layout
  localparam int LIP_ST_RUN_BIT = 0;
  localparam int LIP_ST_SLOT_LSB = 4;
  localparam int LIP_ST_SUB_LSB = 8;

  // reset values: master at zero keeps the oscillator stopped until software enables it
  localparam logic [7:0] LIP_RST_MASTER_NINTH = 8'h00;
  localparam logic [7:0] LIP_RST_FIRST_SECOND = 8'h00;

  // code values
  localparam logic [3:0] LIP_CODE_OFF = 4'h0;
  localparam logic [3:0] LIP_CODE_FULL = 4'hf;
  localparam logic [3:0] LIP_MASTER_LAST_SUB = 4'he;
  localparam logic [3:0] LIP_LAST_SLOT = 4'hf;

  // internal oscillator period in ns and the system clock period in ns
  localparam int LIP_SYS_CLK_NS = 8;
  localparam int LIP_OSC_TICK_NS = 64;
  localparam logic [15:0] LIP_OSC_DIV_CYC =
    16'((LIP_OSC_TICK_NS + LIP_SYS_CLK_NS - 1) / LIP_SYS_CLK_NS);

  localparam int LIP_NUM_PINS = 3;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [LIP_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } lip_apb_req_t;

  typedef struct packed {
    logic ninth_port_pin;
    logic second_port_pin;
    logic first_port_pin;
  } lip_pins_t;
endpackage
`default_nettype wire

// File: tb/lip_monitor.sv
// concurrent checks on the led intensity block ports
`default_nettype none
module lip_monitor (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire lip_pkg::lip_apb_req_t apb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic first_port_pin_o,
  input wire logic second_port_pin_o,
  input wire logic ninth_port_pin_o,
  input wire logic osc_running_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import lip_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire logic acc = apb_i.psel && apb_i.penable && pready_o;
  wire logic hit = apb_i.paddr == 12'h038 || apb_i.paddr == 12'h040;
  a_ready_after_setup: assert property (
    apb_i.psel && !apb_i.penable |=> pready_o) else $error("no ready after setup");
  a_ready_one_cycle: assert property (
    pready_o |=> !pready_o) else $error("ready held too long");
  a_err_needs_ready: assert property (
    pslverr_o |-> pready_o) else $error("error without ready");
  a_mapped_okay: assert property (
    acc && hit |-> !pslverr_o) else $error("error on intensity register");
  a_unmapped_err: assert property (
    acc && !hit && apb_i.paddr != 12'h004 |-> pslverr_o) else $error("unmapped not refused");
  a_err_read_zero: assert property (
    acc && pslverr_o && !apb_i.pwrite |-> prdata_o == 32'h0) else $error("refused read data");
  a_osc_follows_master: assert property (
    acc && apb_i.pwrite && apb_i.paddr == 12'h038 && apb_i.pstrb[0]
    |-> ##2 osc_running_o == ($past(apb_i.pwdata[7:4], 2) != 4'h0)) else $error("osc state");
  a_stopped_pins_low: assert property (
    !osc_running_o |-> !first_port_pin_o && !second_port_pin_o && !ninth_port_pin_o)
    else $error("pin active while stopped");
  cover property (acc && pslverr_o);
  cover property (osc_running_o && first_port_pin_o);
  cover property ($rose(ninth_port_pin_o));
endmodule
bind lip_top lip_monitor lip_monitor_i (.*);
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the led intensity block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lip_pkg::*;
  localparam int PER = 240 * int'(LIP_OSC_DIV_CYC);
  logic clk = 1'b0;
  logic rst = 1'b1;
  lip_apb_req_t apb = '0;
  logic [31:0] prdata;
  logic pready, pslverr, p1, p2, p9, osc;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h3f520e36;
  // last accepted byte of each intensity register, for masked writes
  logic [7:0] shadow [2] = '{8'h00, 8'h00};
  lip_top lip_top_i (.sys_clk_i(clk), .rst_i(rst), .apb_i(apb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .first_port_pin_o(p1),
    .second_port_pin_o(p2), .ninth_port_pin_o(p9), .osc_running_o(osc));
  initial begin
    forever #4 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // high cycles over one full period; code f stays on whenever master is nonzero
  function automatic int exp_high(input logic [3:0] c, input logic [3:0] m);
    if (m == 4'h0) return 0;
    if (c == 4'hf) return PER;
    return (int'(c) + 1) * int'(m) * int'(LIP_OSC_DIV_CYC);
  endfunction
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
    @(posedge clk);
    // bit 31 of random write data also clears the low byte strobe
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d,
      pstrb: wr ? {3'b111, ~d[31]} : 4'hf};
    @(posedge clk);
    apb.penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb <= '0;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    logic [31:0] rd, d;
    logic err;
    logic [3:0] g;
    int h1, h2, h9;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    xfer(1'b0, 12'h038, 32'h0, rd, err);
    chk(rd, 32'h0);
    xfer(1'b0, 12'h040, 32'h0, rd, err);
    chk(rd, 32'h0);
    for (int i = 0; i < 8; i++) begin
      d = rnd();
      xfer(1'b1, i[0] ? 12'h040 : 12'h038, d, rd, err);
      xfer(1'b0, i[0] ? 12'h040 : 12'h038, 32'h0, rd, err);
      if (!d[31]) begin
        shadow[i[0]] = d[7:0];
      end
      chk(rd, {24'h0, shadow[i[0]]});
      chk(32'(err), 32'h0);
    end
    xfer(1'b0, 12'h07c, 32'h0, rd, err);
    chk(32'(err), 32'h1);
    xfer(1'b1, 12'h004, 32'h0, rd, err);
    chk(32'(err), 32'h1);
    for (int m = 0; m < 16; m++) begin
      g = (m == 3) ? 4'hf : 4'(rnd());
      xfer(1'b1, 12'h040, {24'h0, 4'(15 - m), 4'(m)}, rd, err);
      xfer(1'b1, 12'h038, {24'h0, 4'(m), g}, rd, err);
      h1 = 0;
      h2 = 0;
      h9 = 0;
      repeat (4) @(posedge clk);
      repeat (PER) begin
        @(posedge clk);
        h1 += int'(p1 === 1'b1);
        h2 += int'(p2 === 1'b1);
        h9 += int'(p9 === 1'b1);
      end
      chk(32'(h1), 32'(exp_high(4'(m), 4'(m))));
      chk(32'(h2), 32'(exp_high(4'(15 - m), 4'(m))));
      chk(32'(h9), 32'(exp_high(g, 4'(m))));
      chk(32'(osc), 32'(m != 0));
      xfer(1'b0, 12'h004, 32'h0, rd, err);
      chk(32'(rd[0]), 32'(m != 0));
      chk(32'(err), 32'h0);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
